// ==== hdl/roc_codec.sv ====
// Purpose: outer RS(208,192) codec with depth-4 interleave and scramblers
// Assumes: same-clock byte streams from framing unit and inner FEC
// Notes:   rs enable is a front-panel level, synchronised here
// Functional notes
// - symbol arithmetic uses GF(256) built on x^8+x^7+x^2+x+1.
// - the generator is the product of (x - alpha^i) for i = 120 to 135.
// - bit 7 of a symbol is the alpha^7 coefficient, bit 0 the constant term.
// - encoding is systematic, info symbols pass unaltered, 16 checks follow.
// - the 47 leading zero symbols of the full codeword are implied and never sent.
// - each codeword is 208 symbols with 192 info symbols; errors are only flagged, never corrected.
// - this is the outer code ahead of the inner rate 3/4 convolutional coder.
// - four codewords are block interleaved whole, symbol by symbol.
// - interleaved output is dealt round robin to three inner encoder lanes.
// - transmit order is scrambler, RS encoder, interleaver, then FEC encoder.
// - receive order is de-interleaver, RS decoder, then descrambler.
// - the RS stage can be switched in or out of both paths.
// - every 24 codewords the last two checks of the last two codewords carry the unique word.
// - the decoder treats the unique-word positions as erasures.
// - with RS off a self-synchronising scrambler runs, with RS on the synchronous one.
// - the first transmitted bit of an octet is the symbol msb.
`timescale 1ns/1ns
module roc_codec
	import roc_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// front panel
	input  wire logic        rs_enable_pin,
	output      logic        init_busy,
	// transmit from framing unit
	input  wire logic [7:0]  tx_in_data,
	input  wire logic        tx_in_valid,
	output      logic        tx_in_ready,
	// transmit to inner encoders
	output      roc_fec_t    tx_out,
	output      logic        tx_out_valid,
	input  wire logic        tx_out_ready,
	// receive from inner decoders
	input  wire logic [7:0]  rx_in_data,
	input  wire logic        rx_in_valid,
	output      logic        rx_in_ready,
	// receive to framing unit
	output      logic [7:0]  rx_out_data,
	output      logic        rx_out_valid,
	input  wire logic        rx_out_ready,
	output      roc_status_t rx_status
);

	// ----------------------------------------------------------------
	// mode sync and generator build
	// ----------------------------------------------------------------
	logic       en_s1, en_s2, en_prev;
	logic       mode_chg;
	logic [7:0] gen_cnt_reg, gen_cnt_next;
	logic [7:0] root_reg, root_next;
	logic [7:0] g_reg [NPAR+1], g_next [NPAR+1];
	logic [7:0] rts_reg [NPAR], rts_next [NPAR];
	logic       busy_reg, busy_next;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			en_s1   <= 1'b0;
			en_s2   <= 1'b0;
			en_prev <= 1'b0;
		end
		else
		begin
			en_s1   <= rs_enable_pin;
			en_s2   <= en_s1;
			en_prev <= en_s2;
		end
	assign mode_chg  = en_s2 != en_prev;
	assign init_busy = busy_reg;

	// coefficients are built once, so no table of magic numbers is kept
	always_comb
	begin
		gen_cnt_next = gen_cnt_reg;
		root_next    = root_reg;
		g_next       = g_reg;
		rts_next     = rts_reg;
		busy_next    = busy_reg;
		if (busy_reg)
		begin
			root_next    = roc_gf_mul(root_reg, ALPHA);
			gen_cnt_next = gen_cnt_reg + 8'h01;
			if (gen_cnt_reg >= 8'(FIRST_ROOT))
			begin
				rts_next[4'(gen_cnt_reg - 8'(FIRST_ROOT))] = root_reg;
				g_next[0] = roc_gf_mul(g_reg[0], root_reg);
				for (int j = 1; j <= NPAR; j++)
					g_next[j] = g_reg[j-1] ^ roc_gf_mul(g_reg[j], root_reg);
			end
			if (gen_cnt_reg == 8'(INIT_LAST))
				busy_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			gen_cnt_reg <= 8'h00;
			root_reg    <= GF_ONE;
			busy_reg    <= 1'b1;
			for (int j = 0; j <= NPAR; j++)
				g_reg[j] <= (j == 0) ? GF_ONE : 8'h00;
			for (int j = 0; j < NPAR; j++)
				rts_reg[j] <= 8'h00;
		end
		else
		begin
			gen_cnt_reg <= gen_cnt_next;
			root_reg    <= root_next;
			busy_reg    <= busy_next;
			g_reg       <= g_next;
			rts_reg     <= rts_next;
		end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	logic [7:0]  tmem [BLK_LEN];
	roc_state_t  ts_reg, ts_next;
	logic [7:0]  tsym_reg, tsym_next;
	logic [1:0]  tcw_reg, tcw_next;
	logic [9:0]  trd_reg, trd_next;
	logic [2:0]  tblk_reg, tblk_next;
	logic [14:0] tscr_reg, tscr_next;
	logic [7:0]  par_reg [NPAR], par_next [NPAR];
	roc_fec_t    tout_reg, tout_next;
	logic        tov_reg, tov_next;
	logic        t_free, t_we;
	logic [9:0]  t_wa, t_ra;
	logic [7:0]  t_wd, t_fb;
	logic [22:0] t_scr;

	assign t_free       = !tov_reg || tx_out_ready;
	assign t_wa         = 10'(int'(tcw_reg) * N_SHORT + int'(tsym_reg));
	assign t_ra         = 10'(int'(trd_reg[1:0]) * N_SHORT + int'(trd_reg[9:2]));
	assign tx_out       = tout_reg;
	assign tx_out_valid = tov_reg;
	assign tx_in_ready  = !busy_reg && !mode_chg && (en_s2 ? ts_reg == ST_FILL : t_free);

	always_comb
	begin
		ts_next   = ts_reg;
		tsym_next = tsym_reg;
		tcw_next  = tcw_reg;
		trd_next  = trd_reg;
		tblk_next = tblk_reg;
		tscr_next = tscr_reg;
		par_next  = par_reg;
		tout_next = tout_reg;
		tov_next  = tov_reg && !tx_out_ready;
		t_we      = 1'b0;
		t_wd      = 8'h00;
		t_fb      = 8'h00;
		t_scr     = roc_scr(tscr_reg, tx_in_data, !en_s2, 1'b0);
		if (en_s2 && tblk_reg == 3'h0 && tcw_reg == 2'h0 && tsym_reg == 8'h00)
			t_scr = roc_scr(SCR_SEED, tx_in_data, 1'b0, 1'b0);
		if (mode_chg)
		begin
			ts_next   = ST_FILL;
			tsym_next = 8'h00;
			tcw_next  = 2'h0;
			trd_next  = 10'h000;
			tblk_next = 3'h0;
			// register holds the last lane used, so the first block byte lands on LANE_START
			tout_next.lane = LANE_START - 2'h1;
			for (int j = 0; j < NPAR; j++)
				par_next[j] = 8'h00;
		end
		else if (!en_s2)
		begin
			if (tx_in_valid && tx_in_ready)
			begin
				tscr_next = t_scr[22:8];
				tout_next.data = t_scr[7:0];
				tout_next.lane = (tout_reg.lane == 2'(LANES-1)) ? 2'h0 : tout_reg.lane + 2'h1;
				tov_next  = 1'b1;
			end
		end
		else
			unique case (ts_reg)
				ST_INIT:
					if (!busy_reg)
						ts_next = ST_FILL;
				ST_FILL:
					if (tx_in_valid)
					begin
						tscr_next = t_scr[22:8];
						t_we      = 1'b1;
						t_wd      = t_scr[7:0];
						t_fb      = t_scr[7:0] ^ par_reg[NPAR-1];
						par_next[0] = roc_gf_mul(g_reg[0], t_fb);
						for (int j = 1; j < NPAR; j++)
							par_next[j] = par_reg[j-1] ^ roc_gf_mul(g_reg[j], t_fb);
						tsym_next = tsym_reg + 8'h01;
						if (tsym_reg == 8'(K_SHORT - 1))
							ts_next = ST_PARITY;
					end
				ST_PARITY:
				begin
					t_we        = 1'b1;
					t_wd        = par_reg[NPAR-1];
					par_next[0] = 8'h00;
					for (int j = 1; j < NPAR; j++)
						par_next[j] = par_reg[j-1];
					tsym_next = tsym_reg + 8'h01;
					if (tsym_reg == 8'(N_SHORT - 1))
					begin
						tsym_next = 8'h00;
						tcw_next  = tcw_reg + 2'h1;
						ts_next   = (tcw_reg == 2'(DEPTH-1)) ? ST_DRAIN : ST_FILL;
					end
				end
				ST_DRAIN:
					if (t_free)
					begin
						tout_next.data = tmem[t_ra];
						if (tblk_reg == 3'(UW_BLKS-1) && trd_reg >= 10'(UW_FIRST) && trd_reg[1])
							tout_next.data = UW_WORD[31 - 8 * int'({trd_reg[2], trd_reg[0]}) -: 8];
						tout_next.lane = (tout_reg.lane == 2'(LANES-1)) ? 2'h0 : tout_reg.lane + 2'h1;
						tov_next  = 1'b1;
						trd_next  = trd_reg + 10'h001;
						if (trd_reg == 10'(BLK_LEN - 1))
						begin
							trd_next  = 10'h000;
							ts_next   = ST_FILL;
							tblk_next = (tblk_reg == 3'(UW_BLKS-1)) ? 3'h0 : tblk_reg + 3'h1;
						end
					end
				default:
					ts_next = ST_INIT;
			endcase
	end

	always_ff @(posedge ref_clk)
		if (t_we)
			tmem[t_wa] <= t_wd;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			ts_reg   <= ST_INIT;
			tsym_reg <= 8'h00;
			tcw_reg  <= 2'h0;
			trd_reg  <= 10'h000;
			tblk_reg <= 3'h0;
			tscr_reg <= SCR_SEED;
			tout_reg <= '{data: 8'h00, lane: LANE_START};
			tov_reg  <= 1'b0;
			for (int j = 0; j < NPAR; j++)
				par_reg[j] <= 8'h00;
		end
		else
		begin
			ts_reg   <= ts_next;
			tsym_reg <= tsym_next;
			tcw_reg  <= tcw_next;
			trd_reg  <= trd_next;
			tblk_reg <= tblk_next;
			tscr_reg <= tscr_next;
			tout_reg <= tout_next;
			tov_reg  <= tov_next;
			par_reg  <= par_next;
		end

	// ----------------------------------------------------------------
	// receive path
	// ----------------------------------------------------------------
	// block alignment is taken from reset or mode change; sync search lives upstream
	logic [7:0]  rmem [BLK_LEN];
	roc_state_t  rs_reg, rs_next;
	logic [9:0]  rwr_reg, rwr_next;
	logic [7:0]  rsym_reg, rsym_next;
	logic [1:0]  rcw_reg, rcw_next;
	logic [2:0]  rblk_reg, rblk_next;
	logic [14:0] rscr_reg, rscr_next;
	logic [7:0]  syn_reg [NPAR], syn_next [NPAR];
	logic [7:0]  rout_reg, rout_next;
	logic        rov_reg, rov_next;
	roc_status_t rst_reg, rst_next;
	logic        r_free, r_go, r_ers, r_bad;
	logic [7:0]  r_sym;
	logic [22:0] r_scr;

	assign r_free       = !rov_reg || rx_out_ready;
	assign r_sym        = rmem[10'(int'(rsym_reg) * DEPTH + int'(rcw_reg))];
	assign r_go         = rsym_reg >= 8'(K_SHORT) || r_free;
	assign r_ers        = rblk_reg == 3'(UW_BLKS-1) && rcw_reg >= 2'h2;
	assign rx_in_ready  = !busy_reg && !mode_chg && (en_s2 ? rs_reg == ST_FILL : r_free);
	assign rx_out_data  = rout_reg;
	assign rx_out_valid = rov_reg;
	assign rx_status    = rst_reg;

	always_comb
	begin
		rs_next   = rs_reg;
		rwr_next  = rwr_reg;
		rsym_next = rsym_reg;
		rcw_next  = rcw_reg;
		rblk_next = rblk_reg;
		rscr_next = rscr_reg;
		syn_next  = syn_reg;
		rout_next = rout_reg;
		rov_next  = rov_reg && !rx_out_ready;
		rst_next  = '{cw_done: 1'b0, uncorr: rst_reg.uncorr};
		r_bad     = 1'b0;
		r_scr     = roc_scr(rscr_reg, rx_in_data, !en_s2, 1'b1);
		if (en_s2)
			r_scr = roc_scr((rblk_reg == 3'h0 && rcw_reg == 2'h0 && rsym_reg == 8'h00)
				? SCR_SEED : rscr_reg, r_sym, 1'b0, 1'b1);
		if (mode_chg)
		begin
			rs_next   = ST_FILL;
			rwr_next  = 10'h000;
			rsym_next = 8'h00;
			rcw_next  = 2'h0;
			rblk_next = 3'h0;
		end
		else if (!en_s2)
		begin
			if (rx_in_valid && rx_in_ready)
			begin
				rscr_next = r_scr[22:8];
				rout_next = r_scr[7:0];
				rov_next  = 1'b1;
			end
		end
		else
			unique case (rs_reg)
				ST_INIT:
					if (!busy_reg)
						rs_next = ST_FILL;
				ST_FILL:
					if (rx_in_valid)
					begin
						rwr_next = rwr_reg + 10'h001;
						if (rwr_reg == 10'(BLK_LEN - 1))
						begin
							rwr_next = 10'h000;
							rs_next  = ST_DRAIN;
						end
					end
				ST_DRAIN:
					if (r_go)
					begin
						for (int i = 0; i < NPAR; i++)
							syn_next[i] = ((rsym_reg == 8'h00) ? 8'h00
								: roc_gf_mul(syn_reg[i], rts_reg[i])) ^ r_sym;
						if (rsym_reg < 8'(K_SHORT))
						begin
							rscr_next = r_scr[22:8];
							rout_next = r_scr[7:0];
							rov_next  = 1'b1;
						end
						rsym_next = rsym_reg + 8'h01;
						if (rsym_reg == 8'(N_SHORT - 1))
						begin
							rst_next.cw_done = 1'b1;
							rsym_next = 8'h00;
							rcw_next  = rcw_reg + 2'h1;
							if (rcw_reg == 2'(DEPTH-1))
							begin
								rs_next   = ST_FILL;
								rblk_next = (rblk_reg == 3'(UW_BLKS-1)) ? 3'h0 : rblk_reg + 3'h1;
							end
						end
					end
				default:
					rs_next = ST_INIT;
			endcase
		// judged after the symbol update, so the last symbol is in the syndromes
		// two erasures at degrees 1 and 0: all syndromes must fit e0 + e1*root
		for (int i = 1; i < NPAR; i++)
			if (r_ers)
				r_bad = r_bad || roc_gf_mul(syn_next[i] ^ syn_next[0], rts_reg[1] ^ rts_reg[0])
					!= roc_gf_mul(syn_next[1] ^ syn_next[0], rts_reg[i] ^ rts_reg[0]);
		for (int i = 0; i < NPAR; i++)
			if (!r_ers)
				r_bad = r_bad || syn_next[i] != 8'h00;
		if (rst_next.cw_done)
			rst_next.uncorr = r_bad;
	end

	always_ff @(posedge ref_clk)
		if (en_s2 && rs_reg == ST_FILL && rx_in_valid && !mode_chg)
			rmem[rwr_reg] <= rx_in_data;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			rs_reg   <= ST_INIT;
			rwr_reg  <= 10'h000;
			rsym_reg <= 8'h00;
			rcw_reg  <= 2'h0;
			rblk_reg <= 3'h0;
			rscr_reg <= SCR_SEED;
			rout_reg <= 8'h00;
			rov_reg  <= 1'b0;
			rst_reg  <= '{cw_done: 1'b0, uncorr: 1'b0};
			for (int i = 0; i < NPAR; i++)
				syn_reg[i] <= 8'h00;
		end
		else
		begin
			rs_reg   <= rs_next;
			rwr_reg  <= rwr_next;
			rsym_reg <= rsym_next;
			rcw_reg  <= rcw_next;
			rblk_reg <= rblk_next;
			rscr_reg <= rscr_next;
			rout_reg <= rout_next;
			rov_reg  <= rov_next;
			rst_reg  <= rst_next;
			syn_reg  <= syn_next;
		end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	init_done_a: assert property (busy_reg && gen_cnt_reg == 8'(INIT_LAST) |=> !busy_reg && g_reg[NPAR] == GF_ONE) else $error("generator build did not finish");
	parity_stall_a: assert property (ts_reg == ST_PARITY |-> !tx_in_ready) else $error("input taken during check symbols");
	parity_len_a: assert property ($rose(ts_reg == ST_PARITY) && !mode_chg && en_s2 |-> ##16 ts_reg != ST_PARITY) else $error("check symbol run is not 16");
	drain_end_a: assert property (en_s2 && !mode_chg && ts_reg == ST_DRAIN && t_free && trd_reg == 10'(BLK_LEN - 1) |=> ts_reg == ST_FILL && tcw_reg == 2'h0) else $error("interleave block length wrong");
	uw_last_a: assert property (en_s2 && !mode_chg && ts_reg == ST_DRAIN && t_free && tblk_reg == 3'(UW_BLKS-1) && trd_reg == 10'(BLK_LEN - 1) |=> tov_reg && tout_reg.data == UW_WORD[7:0] && tout_reg.lane == 2'h0) else $error("unique word end misplaced");
	lane_rot_a: assert property (tov_reg && tx_out_ready ##1 tov_reg && !$past(mode_chg) |-> tout_reg.lane == (($past(tout_reg.lane) == 2'h2) ? 2'h0 : $past(tout_reg.lane) + 2'h1)) else $error("lane order broken");
	bypass_a: assert property (!en_s2 && !mode_chg && tx_in_valid && tx_in_ready |=> tov_reg) else $error("bypass byte lost");
	cw_flag_a: assert property (en_s2 && !mode_chg && rs_reg == ST_DRAIN && r_go && rsym_reg == 8'(N_SHORT - 1) |=> rst_reg.cw_done ##1 !rst_reg.cw_done) else $error("codeword status pulse wrong");
	rx_info_a: assert property (en_s2 && rs_reg == ST_DRAIN && rsym_reg >= 8'(K_SHORT) && !rov_reg |=> !rov_reg) else $error("check symbol leaked to output");

	uw_sent_c: cover property (tov_reg && tout_reg.data == UW_WORD[7:0] && tblk_reg == 3'h0);
	uncorr_c: cover property (rst_reg.cw_done && rst_reg.uncorr);
	clean_c: cover property (rst_reg.cw_done && !rst_reg.uncorr && rblk_reg == 3'(UW_BLKS-1));
	bypass_c: cover property (!en_s2 && rov_reg && tov_reg);

endmodule // roc_codec

// ==== hdl/roc_pkg.sv ====
// Purpose: constants, types and field arithmetic for the outer RS codec
// Assumes: byte-wide streams, first transmitted bit of each octet is bit 7
// Notes:   shared by the codec core, the FEC model and the bench
package roc_pkg;

	// ----------------------------------------------------------------
	// code and field
	// ----------------------------------------------------------------
	localparam int N_SHORT     = 208;
	localparam int K_SHORT     = 192;
	localparam int NPAR        = 16;
	localparam int DEPTH       = 4;
	localparam int BLK_LEN     = 832;
	localparam int FIRST_ROOT  = 120;
	localparam int INIT_LAST   = 135;
	localparam int LANES       = 3;
	localparam int UW_BLKS     = 6;
	localparam int UW_FIRST    = 826;
	localparam logic [7:0]  FIELD_POLY_LOW = 8'h87;
	localparam logic [7:0]  ALPHA          = 8'h02;
	localparam logic [7:0]  GF_ONE         = 8'h01;
	localparam logic [31:0] UW_WORD        = 32'h5A0FBE66;
	localparam logic [14:0] SCR_SEED       = 15'h1249;
	localparam logic [1:0]  LANE_START     = 2'h1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_INIT, ST_FILL, ST_PARITY, ST_DRAIN} roc_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic [1:0] lane;
	} roc_fec_t;

	typedef struct packed {
		logic cw_done;
		logic uncorr;
	} roc_status_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] roc_gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? FIELD_POLY_LOW : 8'h00);
		end
		return p;
	endfunction

	// one octet through a 1 + x^-14 + x^-15 register, msb first
	function automatic logic [22:0] roc_scr(input logic [14:0] s, input logic [7:0] d,
		input logic self_sync, input logic descr);
		logic [14:0] st;
		logic [7:0]  o;
		logic        fb;
		st = s;
		o  = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			fb   = st[1] ^ st[0];
			o[i] = d[i] ^ fb;
			if (!self_sync)
				st = {fb, st[14:1]};
			else if (descr)
				st = {d[i], st[14:1]};
			else
				st = {o[i], st[14:1]};
		end
		return {st, o};
	endfunction

endpackage

// ==== dv/roc_fec_model.sv ====
// Purpose: inner FEC stand-in, loops coded bytes back to the receiver
// Assumes: identity inner code, one clock
// Notes:   slow halves ready, flip_at corrupts one looped byte
`timescale 1ns/1ns
module roc_fec_model
	import roc_pkg::*;
(
	// clock
	input  wire logic        ref_clk,
	// from transmit path
	input  wire roc_fec_t    tx_out,
	input  wire logic        tx_out_valid,
	output      logic        tx_out_ready,
	// to receive path
	output      logic [7:0]  rx_in_data,
	output      logic        rx_in_valid,
	input  wire logic        rx_in_ready,
	// control
	input  wire logic        slow,
	input  wire logic [15:0] flip_at
);
	// ------------------------------
	// loopback
	// ------------------------------
	roc_fec_t   seen[$];
	logic [7:0] loopq[$];
	roc_fec_t   cap;
	logic       tx_take;
	logic       rx_take;
	int         n_tx;

	initial
	begin
		tx_out_ready = 1'b0;
		rx_in_valid  = 1'b0;
		rx_in_data   = 8'hA5;
		tx_take      = 1'b0;
		rx_take      = 1'b0;
		n_tx         = 0;
		forever
		begin
			@(posedge ref_clk);
			if (tx_take)
			begin
				seen.push_back(cap);
				loopq.push_back(n_tx == int'(flip_at) ? cap.data ^ 8'h01 : cap.data);
				n_tx++;
			end
			if (rx_take)
				void'(loopq.pop_front());
			@(negedge ref_clk);
			// slow mode stalls every other cycle, like a busy encoder
			tx_out_ready = slow ? ~tx_out_ready : 1'b1;
			rx_in_valid  = (loopq.size() > 0);
			// released data toggles so a stale byte never looks valid
			rx_in_data   = rx_in_valid ? loopq[0] : ~rx_in_data;
			#1;
			tx_take = tx_out_valid & tx_out_ready;
			rx_take = rx_in_valid & rx_in_ready;
			cap     = tx_out;
		end
	end
endmodule // roc_fec_model

// ==== dv/rs_outer_codec_interleave_bench.sv ====
// Purpose: self-checking bench for the outer RS codec in loopback
// Assumes: partner model returns every coded byte in order
// Notes:   expected streams are rebuilt here from the coding rules
`timescale 1ns/1ns
module rs_outer_codec_interleave_bench
	import roc_pkg::*;
;
	logic        ref_clk;
	logic        rst_b;
	logic        rs_enable_pin;
	logic        init_busy;
	logic [7:0]  tx_in_data;
	logic        tx_in_valid;
	logic        tx_in_ready;
	roc_fec_t    tx_out;
	logic        tx_out_valid;
	logic        tx_out_ready;
	logic [7:0]  rx_in_data;
	logic        rx_in_valid;
	logic        rx_in_ready;
	logic [7:0]  rx_out_data;
	logic        rx_out_valid;
	logic        rx_out_ready;
	roc_status_t rx_status;
	logic        slow;
	logic [15:0] flip_at;
	int          failures;
	int          checks_done;
	logic [7:0]  sent[$];
	logic [7:0]  rxq[$];
	logic        flags[$];
	logic [15:0] hist;
	logic [14:0] st;

	roc_codec dut (.ref_clk(ref_clk), .rst_b(rst_b), .rs_enable_pin(rs_enable_pin),
		.init_busy(init_busy), .tx_in_data(tx_in_data), .tx_in_valid(tx_in_valid),
		.tx_in_ready(tx_in_ready), .tx_out(tx_out), .tx_out_valid(tx_out_valid),
		.tx_out_ready(tx_out_ready), .rx_in_data(rx_in_data), .rx_in_valid(rx_in_valid),
		.rx_in_ready(rx_in_ready), .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid),
		.rx_out_ready(rx_out_ready), .rx_status(rx_status));

	roc_fec_model fec (.ref_clk(ref_clk), .tx_out(tx_out), .tx_out_valid(tx_out_valid),
		.tx_out_ready(tx_out_ready), .rx_in_data(rx_in_data), .rx_in_valid(rx_in_valid),
		.rx_in_ready(rx_in_ready), .slow(slow), .flip_at(flip_at));

	// ------------------------------
	// helpers
	// ------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever
			#50 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk)
		rx_out_ready <= slow ? ~rx_out_ready : 1'b1;

	// registered outputs read before this edge's updates land
	always @(posedge ref_clk)
	begin
		if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1)
			rxq.push_back(rx_out_data);
		if (rx_status.cw_done === 1'b1)
			flags.push_back(rx_status.uncorr);
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s exp %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic send_byte(input logic [7:0] d);
		int n;
		n = 0;
		@(negedge ref_clk);
		tx_in_data  = d;
		tx_in_valid = 1'b1;
		#1;
		while (tx_in_ready !== 1'b1 && n < 4000)
		begin
			@(negedge ref_clk);
			#1;
			n++;
		end
		check("tx_in_ready", n < 4000, 1);
		sent.push_back(d);
		@(posedge ref_clk);
	endtask

	task automatic wait_out(input int a, input int b);
		int n;
		n = 0;
		@(negedge ref_clk);
		tx_in_valid = 1'b0;
		while ((fec.seen.size() < a || rxq.size() < b) && n < 20000)
		begin
			@(posedge ref_clk);
			n++;
		end
		repeat (60) @(posedge ref_clk);
		check("drain", n < 20000, 1);
	endtask

	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 7; i >= 0; i--)
			p = ({p[6:0], 1'b0} ^ (p[7] ? 8'h87 : 8'h00)) ^ (b[i] ? a : 8'h00);
		return p;
	endfunction

	function automatic logic [7:0] synd_or(input logic [7:0] c[208]);
		logic [7:0] r;
		logic [7:0] s;
		logic [7:0] acc;
		r   = 8'h01;
		acc = 8'h00;
		for (int j = 0; j < 120; j++)
			r = gmul(r, 8'h02);
		for (int j = 0; j < 16; j++)
		begin
			s = 8'h00;
			for (int i = 0; i < 208; i++)
				s = gmul(s, r) ^ c[i];
			acc = acc | s;
			r   = gmul(r, 8'h02);
		end
		return acc;
	endfunction

	function automatic logic [7:0] sync_scr(input logic [7:0] d);
		logic       fb;
		logic [7:0] o;
		for (int i = 7; i >= 0; i--)
		begin
			fb   = st[1] ^ st[0];
			o[i] = d[i] ^ fb;
			st   = {fb, st[14:1]};
		end
		return o;
	endfunction

	function automatic logic [7:0] self_descr(input logic [7:0] c);
		logic [7:0] o;
		for (int i = 7; i >= 0; i--)
		begin
			o[i] = c[i] ^ hist[13] ^ hist[14];
			hist = {hist[14:0], c[i]};
		end
		return o;
	endfunction

	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic test_reset();
		int n;
		n = 0;
		repeat (2) @(negedge ref_clk);
		check("valid", {tx_out_valid, rx_out_valid, rx_status.cw_done}, 0);
		check("lane", tx_out.lane, LANE_START);
		rst_b = 1'b1;
		#1;
		check("ready", {tx_in_ready, rx_in_ready}, 0);
		while (init_busy === 1'b1 && n < 300)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check("init len", n, 136);
	endtask

	task automatic test_bypass();
		slow = 1'b1;
		for (int i = 0; i < 40; i++)
			send_byte(8'(i * 37));
		wait_out(40, 40);
		check("bypass count", fec.seen.size(), 40);
		hist = 16'h0000;
		for (int i = 0; i < 40; i++)
		begin
			if (i >= 2)
				check("self scr", self_descr(fec.seen[i].data), sent[i]);
			else
				void'(self_descr(fec.seen[i].data));
			if (i >= 2)
				check("bypass rx", rxq[i], sent[i]);
			if (i >= 1)
				check("lane", fec.seen[i].lane, (fec.seen[i - 1].lane + 2'd1) % 2'd3);
		end
	endtask

	task automatic test_rs();
		logic [7:0] cw[208];
		logic [7:0] exp_q[$];
		logic [7:0] uw[4];
		int         p;
		uw = '{8'h5A, 8'h0F, 8'hBE, 8'h66};
		@(negedge ref_clk);
		rs_enable_pin = 1'b1;
		repeat (8) @(negedge ref_clk);
		sent.delete();
		rxq.delete();
		flags.delete();
		fec.seen.delete();
		fec.n_tx = 0;
		flip_at  = 16'h0355;
		for (int i = 0; i < 7 * 768; i++)
			send_byte(8'(i * 7 + 3));
		wait_out(7 * 832, 7 * 768);
		for (int i = 0; i < 7 * 768; i++)
		begin
			if (i % 4608 == 0)
				st = 15'h1249;
			exp_q.push_back(sync_scr(sent[i]));
		end
		for (int b = 0; b < 7; b++)
			for (int c = 0; c < 4; c++)
			begin
				for (int s = 0; s < 208; s++)
					cw[s] = fec.seen[b * 832 + 4 * s + c].data;
				for (int s = 0; s < 192; s++)
					check("info", cw[s], exp_q[b * 768 + c * 192 + s]);
				if (b != 5 || c < 2)
					check("syndrome", synd_or(cw), 0);
			end
		for (int k = 0; k < 4; k++)
		begin
			p = 5 * 832 + 826 + k + (k / 2) * 2;
			check("sync word", fec.seen[p].data, uw[k]);
		end
		check("sync lane", fec.seen[5 * 832 + 831].lane, 0);
		for (int i = 1; i < 7 * 832; i++)
			check("lane", fec.seen[i].lane, (fec.seen[i - 1].lane + 2'd1) % 2'd3);
		for (int i = 0; i < 7 * 768; i++)
			check("rx info", rxq[i], sent[i] ^ (i == 965 ? 8'h01 : 8'h00));
		check("cw count", flags.size(), 28);
		for (int k = 0; k < 28; k++)
			check("uncorr", flags[k], k == 5);
	endtask

	// ------------------------------
	// main and watchdog
	// ------------------------------
	initial
	begin
		rst_b         = 1'b0;
		rs_enable_pin = 1'b0;
		tx_in_data    = 8'h00;
		tx_in_valid   = 1'b0;
		rx_out_ready  = 1'b1;
		slow          = 1'b0;
		flip_at       = 16'hFFFF;
		failures      = 0;
		checks_done   = 0;
		hist          = 16'h0000;
		st            = 15'h0000;
		test_reset();
		test_bypass();
		test_rs();
		finish_test();
	end

	// run needs about 20000 cycles, so 60000 means a hang
	initial
	begin
		#6000000;
		failures++;
		finish_test();
	end
endmodule // rs_outer_codec_interleave_bench
